// File: uirq_top.sv
`timescale 1ns/10ps
`include "uirq_regs.svh"
// Function
// - Four interrupt levels: line status, rx data/timeout, tx empty, modem status.
// - Ident bit 0 low while pending; high with bits 3..1 zero when idle.
// - Line status reports 0110, cleared by reading the line state register.
// - Received data reports 0100; level or trigger; cleared by reading rx buffer.
// - Character timeout reports 1100; cleared by reading rx buffer.
// - Ident bit 3 is zero in character mode; set only for timeout.
// - Tx empty reports 0010; cleared by tx write or ident read of it.
// - Modem status reports 0000; cleared by reading the modem state register.
// - Ident bits 4 and 5 always read zero.
// - Ident bits 6 and 7 read one when FIFOs are enabled.
// - Format bits 1..0 pick 5, 6, 7 or 8 data bits.
// - Bit 2 gives two stop bits, or one and a half for 5-bit characters.
// - Receiver checks only the first stop bit.
// - Bit 3 adds parity after data on send and checks it on receive.
// - Bit 4 picks even parity, clear picks odd.
// - Bits 5 and 3 fix the parity bit to the inverse of bit 4.
// - Bit 6 holds the serial output low until cleared.
// - Break only touches the pin; the transmitter keeps shifting.
// - Bit 7 steers offsets 0 and 4 to the divisor latches.
// - The line format register reads back what was written.
// - Each source competes only while its enable bit is set.
module uirq_top #(
    parameter int ADDR_W = 5
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // Wishbone classic slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [ADDR_W-1:0]     wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic [31:0]                wb_dat_o,
    output logic                       wb_ack_o,
    // Receive side events from the receiver and FIFO logic
    input  wire logic                  rx_valid_i,
    input  wire uirq_pkg::uirq_rxchar_t rx_char_i,
    input  wire logic                  rx_break_i,
    input  wire logic                  rx_overrun_i,
    input  wire logic                  rx_trig_i,
    input  wire logic                  rx_timeout_i,
    input  wire logic [7:0]            rx_fifo_data_i,
    // Modem state from the modem block
    input  wire logic                  modem_change_i,
    input  wire logic [7:0]            modem_state_i,
    // Half-bit tick from the baud generator
    input  wire logic                  half_tick_i,
    output logic                       serial_out_pin_o,
    output logic                       rx_buffer_rd_o,
    output logic                       line_state_rd_o,
    output logic                       modem_state_rd_o,
    output logic                       rx_fifo_clr_o,
    output logic                       tx_fifo_clr_o,
    output logic [1:0]                 rx_trig_level_o,
    output logic                       dma_mode_o,
    output logic [15:0]                divisor_o,
    output uirq_pkg::uirq_lcr_t        line_format_o
);
    generate
        if (ADDR_W < 5) begin : g_chk
            $error("uirq_top: ADDR_W must be at least 5");
        end
    endgenerate

    uirq_pkg::uirq_lcr_t line_format_control;
    logic [3:0]  irq_enable_reg;
    logic        fifo_en_reg;
    logic [7:0]  rx_buffer_reg;
    logic        rx_full_reg;
    logic        oe_reg;
    logic        pe_reg;
    logic        fe_reg;
    logic        bi_reg;
    logic        thre_pend_reg;
    logic        thre_seen_reg;
    logic        ms_pend_reg;
    logic [7:0]  div_lo_reg;
    logic [7:0]  div_hi_reg;
    logic [3:0]  iid;
    logic [7:0]  ident;
    logic [7:0]  line_state;
    logic [31:0] rd_next;
    logic        req;
    logic        wr;
    logic        rd;
    logic        wr_thr;
    logic        rd_rbr;
    logic        rd_iir;
    logic        rd_lsr;
    logic        rd_msr;
    logic        pe_now;
    logic        fe_now;
    logic        ls_src;
    logic        rda_src;
    logic        cto_src;
    logic        hold_empty;
    logic        tx_idle;
    logic        txd;
    logic [4:0]  off;

    // A new request is taken once; ack drops in the next cycle
    assign off    = wb_adr_i[4:0];
    assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr     = req && wb_we_i && wb_sel_i[0];
    assign rd     = req && !wb_we_i;
    assign wr_thr = wr && off == `UIRQ_OFF_DATA && !line_format_control.divisor_access_select;
    assign rd_rbr = rd && off == `UIRQ_OFF_DATA && !line_format_control.divisor_access_select;
    assign rd_iir = rd && off == `UIRQ_OFF_IIR;
    assign rd_lsr = rd && off == `UIRQ_OFF_LSR;
    assign rd_msr = rd && off == `UIRQ_OFF_MSR;

    // Bus answer, one wait state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= req ? rd_next : 32'h0000_0000;
        end
    end

    // Receive character checks; later stop bits never reach this block
    always_comb begin
        pe_now = line_format_control.par_en &&
                 (rx_char_i.par != uirq_pkg::uirq_par_bit(rx_char_i.data,
                                                          line_format_control));
        fe_now = !rx_char_i.stop;
    end

    // Line status error bits; a new error in the read cycle survives
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oe_reg <= 1'b0;
            pe_reg <= 1'b0;
            fe_reg <= 1'b0;
            bi_reg <= 1'b0;
        end else begin
            oe_reg <= (oe_reg && !rd_lsr) || rx_overrun_i ||
                      (rx_valid_i && rx_full_reg && !fifo_en_reg && !rd_rbr);
            pe_reg <= (pe_reg && !rd_lsr) || (rx_valid_i && pe_now);
            fe_reg <= (fe_reg && !rd_lsr) || (rx_valid_i && fe_now);
            bi_reg <= (bi_reg && !rd_lsr) || rx_break_i;
        end
    end

    // Character mode receive buffer; FIFO mode keeps data outside
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_buffer_reg <= 8'h00;
            rx_full_reg   <= 1'b0;
        end else if (rx_valid_i && !fifo_en_reg) begin
            rx_buffer_reg <= rx_char_i.data;
            rx_full_reg   <= 1'b1;
        end else if (rd_rbr || fifo_en_reg) begin
            rx_full_reg   <= 1'b0;
        end
    end

    // Tx empty source: raised on the empty edge, dropped by write or ident read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thre_seen_reg <= 1'b1;
            thre_pend_reg <= 1'b0;
        end else begin
            thre_seen_reg <= hold_empty;
            if ((hold_empty && !thre_seen_reg) ||
                (wr && off == `UIRQ_OFF_IER && !line_format_control.divisor_access_select &&
                 wb_dat_i[`UIRQ_IER_THRE] && !irq_enable_reg[`UIRQ_IER_THRE] && hold_empty)) begin
                thre_pend_reg <= 1'b1;
            end else if (wr_thr || (rd_iir && iid == `UIRQ_IID_THRE)) begin
                thre_pend_reg <= 1'b0;
            end
        end
    end

    // Modem change source; a change in the read cycle wins over the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ms_pend_reg <= 1'b0;
        end else if (modem_change_i) begin
            ms_pend_reg <= 1'b1;
        end else if (rd_msr) begin
            ms_pend_reg <= 1'b0;
        end
    end

    // Source levels
    assign ls_src  = oe_reg || pe_reg || fe_reg || bi_reg;
    assign rda_src = fifo_en_reg ? rx_trig_i : rx_full_reg;
    assign cto_src = fifo_en_reg && rx_timeout_i;

    // Priority encoder; recomputed every cycle so the next source shows
    always_comb begin
        if (ls_src && irq_enable_reg[`UIRQ_IER_LS]) begin
            iid = `UIRQ_IID_LS;
        end else if (rda_src && irq_enable_reg[`UIRQ_IER_RDA]) begin
            iid = `UIRQ_IID_RDA;
        end else if (cto_src && irq_enable_reg[`UIRQ_IER_RDA]) begin
            iid = `UIRQ_IID_CTO;
        end else if (thre_pend_reg && irq_enable_reg[`UIRQ_IER_THRE]) begin
            iid = `UIRQ_IID_THRE;
        end else if (ms_pend_reg && irq_enable_reg[`UIRQ_IER_MS]) begin
            iid = `UIRQ_IID_MS;
        end else begin
            iid = `UIRQ_IID_NONE;
        end
    end

    // Ident byte: FIFO flags, two zero bits, code
    assign ident = {fifo_en_reg, fifo_en_reg, 2'h0, iid};

    // Line state byte built from block state
    assign line_state = {1'b0, tx_idle, hold_empty, bi_reg, fe_reg, pe_reg, oe_reg,
                         fifo_en_reg ? 1'b0 : rx_full_reg};

    // Read mux; unmapped offsets read zero
    always_comb begin
        rd_next = 32'h0000_0000;
        case (off)
            `UIRQ_OFF_DATA: begin
                if (line_format_control.divisor_access_select) begin
                    rd_next[7:0] = div_lo_reg;
                end else begin
                    rd_next[7:0] = fifo_en_reg ? rx_fifo_data_i : rx_buffer_reg;
                end
            end
            `UIRQ_OFF_IER: begin
                if (line_format_control.divisor_access_select) begin
                    rd_next[7:0] = div_hi_reg;
                end else begin
                    rd_next[3:0] = irq_enable_reg;
                end
            end
            `UIRQ_OFF_IIR: rd_next[7:0] = ident;
            `UIRQ_OFF_LCR: rd_next[7:0] = line_format_control;
            `UIRQ_OFF_LSR: rd_next[7:0] = line_state;
            `UIRQ_OFF_MSR: rd_next[7:0] = modem_state_i;
            default:       rd_next = 32'h0000_0000;
        endcase
    end

    // Line format register, read back unchanged
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_format_control <= `UIRQ_LCR_RST;
        end else if (wr && off == `UIRQ_OFF_LCR) begin
            line_format_control <= wb_dat_i[7:0];
        end
    end

    // Enable register, only reachable with divisor access off
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_enable_reg <= `UIRQ_IER_RST;
        end else if (wr && off == `UIRQ_OFF_IER && !line_format_control.divisor_access_select) begin
            irq_enable_reg <= wb_dat_i[3:0];
        end
    end

    // Divisor latches behind the access select bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_lo_reg <= 8'(`UIRQ_DIV_RST);
            div_hi_reg <= 8'h00;
        end else if (wr && line_format_control.divisor_access_select) begin
            if (off == `UIRQ_OFF_DATA) begin
                div_lo_reg <= wb_dat_i[7:0];
            end
            if (off == `UIRQ_OFF_IER) begin
                div_hi_reg <= wb_dat_i[7:0];
            end
        end
    end

    // FIFO control; other bits are only taken with the enable bit set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fifo_en_reg     <= 1'b0;
            rx_fifo_clr_o   <= 1'b0;
            tx_fifo_clr_o   <= 1'b0;
            rx_trig_level_o <= `UIRQ_TRIG_RST;
            dma_mode_o      <= 1'b0;
        end else begin
            rx_fifo_clr_o <= 1'b0;
            tx_fifo_clr_o <= 1'b0;
            if (wr && off == `UIRQ_OFF_IIR) begin
                fifo_en_reg <= wb_dat_i[`UIRQ_FCR_EN];
                if (wb_dat_i[`UIRQ_FCR_EN] != fifo_en_reg) begin
                    rx_fifo_clr_o <= 1'b1;
                    tx_fifo_clr_o <= 1'b1;
                end
                if (wb_dat_i[`UIRQ_FCR_EN]) begin
                    rx_fifo_clr_o   <= wb_dat_i[`UIRQ_FCR_RXCLR] || !fifo_en_reg;
                    tx_fifo_clr_o   <= wb_dat_i[`UIRQ_FCR_TXCLR] || !fifo_en_reg;
                    rx_trig_level_o <= wb_dat_i[`UIRQ_FCR_TRIG];
                    dma_mode_o      <= wb_dat_i[`UIRQ_FCR_DMA];
                end
            end
        end
    end

    // Read side-effect strobes for the neighbouring blocks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_buffer_rd_o   <= 1'b0;
            line_state_rd_o  <= 1'b0;
            modem_state_rd_o <= 1'b0;
        end else begin
            rx_buffer_rd_o   <= rd_rbr;
            line_state_rd_o  <= rd_lsr;
            modem_state_rd_o <= rd_msr;
        end
    end

    // Format and divisor outputs, registered copies
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_format_o <= `UIRQ_LCR_RST;
            divisor_o     <= `UIRQ_DIV_RST;
        end else begin
            line_format_o <= line_format_control;
            divisor_o     <= {div_hi_reg, div_lo_reg};
        end
    end

    uirq_tx u_tx (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .half_tick_i  (half_tick_i),
        .load_i       (wr_thr),
        .data_i       (wb_dat_i[7:0]),
        .fmt_i        (line_format_control),
        .hold_empty_o (hold_empty),
        .idle_o       (tx_idle),
        .txd_o        (txd)
    );

    // Break forces the pin only; the shifter above never sees it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            serial_out_pin_o <= 1'b1;
        end else begin
            serial_out_pin_o <= line_format_control.brk ? 1'b0 : txd;
        end
    end
endmodule

// File: uirq_regs.svh
`ifndef UIRQ_REGS_SVH
`define UIRQ_REGS_SVH
// Register byte addresses, one aligned word each
`define UIRQ_OFF_DATA   5'h00
`define UIRQ_OFF_IER    5'h04
`define UIRQ_OFF_IIR    5'h08
`define UIRQ_OFF_LCR    5'h0c
`define UIRQ_OFF_LSR    5'h14
`define UIRQ_OFF_MSR    5'h18
// Identification codes, bits 3..0
`define UIRQ_IID_NONE   4'h1
`define UIRQ_IID_LS     4'h6
`define UIRQ_IID_RDA    4'h4
`define UIRQ_IID_CTO    4'hc
`define UIRQ_IID_THRE   4'h2
`define UIRQ_IID_MS     4'h0
// Enable bit positions
`define UIRQ_IER_RDA    0
`define UIRQ_IER_THRE   1
`define UIRQ_IER_LS     2
`define UIRQ_IER_MS     3
// FIFO control bit positions
`define UIRQ_FCR_EN     0
`define UIRQ_FCR_RXCLR  1
`define UIRQ_FCR_TXCLR  2
`define UIRQ_FCR_DMA    3
`define UIRQ_FCR_TRIG   7:6
// Reset values
`define UIRQ_LCR_RST    8'h00
`define UIRQ_IER_RST    4'h0
`define UIRQ_DIV_RST    16'h0001
`define UIRQ_TRIG_RST   2'h0
// Stop and bit lengths in half-bit ticks; 5-bit length code
`define UIRQ_STOP_H1    3'h2
`define UIRQ_STOP_H15   3'h3
`define UIRQ_STOP_H2    3'h4
`define UIRQ_HALF_BIT   3'h2
`define UIRQ_LEN_5      2'h0
`endif

// File: uirq_pkg.sv
package uirq_pkg;
    // Line format register, bit 7 down to bit 0
    typedef struct packed {
        logic       divisor_access_select;
        logic       brk;
        logic       stick;
        logic       even;
        logic       par_en;
        logic       stop2;
        logic [1:0] len;
    } uirq_lcr_t;

    // One received character with its parity and first stop bit
    typedef struct packed {
        logic [7:0] data;
        logic       par;
        logic       stop;
    } uirq_rxchar_t;

    typedef enum logic [2:0] {
        UIRQ_TX_IDLE  = 3'h0,
        UIRQ_TX_START = 3'h1,
        UIRQ_TX_DATA  = 3'h3,
        UIRQ_TX_PAR   = 3'h2,
        UIRQ_TX_STOP  = 3'h6
    } uirq_tx_state_t;

    // Parity bit to send or expect for the selected length and mode
    function automatic logic uirq_par_bit(input logic [7:0] d, input uirq_lcr_t f);
        logic x;
        x = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (i < 5 + int'(f.len)) begin
                x = x ^ d[i];
            end
        end
        if (f.stick) begin
            return ~f.even;
        end
        return f.even ? x : ~x;
    endfunction
endpackage

// File: uirq_tx.sv
`timescale 1ns/10ps
`include "uirq_regs.svh"
// Character transmitter: one holding register and one shift register
module uirq_tx (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               half_tick_i,
    input  wire logic               load_i,
    input  wire logic [7:0]         data_i,
    input  wire uirq_pkg::uirq_lcr_t fmt_i,
    output logic                    hold_empty_o,
    output logic                    idle_o,
    output logic                    txd_o
);
    uirq_pkg::uirq_tx_state_t state_reg;
    logic [7:0] hold_reg;
    logic [7:0] shift_reg;
    logic [2:0] half_reg;
    logic [2:0] bit_reg;
    logic [2:0] stop_h;

    // Stop length in half bits
    always_comb begin
        if (!fmt_i.stop2) begin
            stop_h = `UIRQ_STOP_H1;
        end else if (fmt_i.len == `UIRQ_LEN_5) begin
            stop_h = `UIRQ_STOP_H15;
        end else begin
            stop_h = `UIRQ_STOP_H2;
        end
    end

    // Holding register; a load while full overwrites
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_empty_o <= 1'b1;
            hold_reg     <= 8'h00;
        end else if (load_i) begin
            hold_empty_o <= 1'b0;
            hold_reg     <= data_i;
        end else if (state_reg == uirq_pkg::UIRQ_TX_IDLE && !hold_empty_o) begin
            hold_empty_o <= 1'b1;
        end
    end

    // Shift sequence; break never reaches here, so shifting goes on
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= uirq_pkg::UIRQ_TX_IDLE;
            shift_reg <= 8'h00;
            half_reg  <= 3'h0;
            bit_reg   <= 3'h0;
            txd_o     <= 1'b1;
        end else begin
            case (state_reg)
                uirq_pkg::UIRQ_TX_IDLE: begin
                    txd_o <= 1'b1;
                    if (!hold_empty_o && !load_i) begin
                        shift_reg <= hold_reg;
                        state_reg <= uirq_pkg::UIRQ_TX_START;
                        half_reg  <= 3'h0;
                        txd_o     <= 1'b0;
                    end
                end
                uirq_pkg::UIRQ_TX_START: begin
                    if (half_tick_i) begin
                        half_reg <= half_reg + 3'h1;
                        if (half_reg + 3'h1 == `UIRQ_HALF_BIT) begin
                            half_reg  <= 3'h0;
                            bit_reg   <= 3'h0;
                            txd_o     <= shift_reg[0];
                            state_reg <= uirq_pkg::UIRQ_TX_DATA;
                        end
                    end
                end
                uirq_pkg::UIRQ_TX_DATA: begin
                    if (half_tick_i) begin
                        half_reg <= half_reg + 3'h1;
                        if (half_reg + 3'h1 == `UIRQ_HALF_BIT) begin
                            half_reg <= 3'h0;
                            bit_reg  <= bit_reg + 3'h1;
                            if (bit_reg == 3'(3'h4 + {1'b0, fmt_i.len})) begin
                                if (fmt_i.par_en) begin
                                    txd_o     <= uirq_pkg::uirq_par_bit(shift_reg, fmt_i);
                                    state_reg <= uirq_pkg::UIRQ_TX_PAR;
                                end else begin
                                    txd_o     <= 1'b1;
                                    state_reg <= uirq_pkg::UIRQ_TX_STOP;
                                end
                            end else begin
                                txd_o <= shift_reg[bit_reg + 3'h1];
                            end
                        end
                    end
                end
                uirq_pkg::UIRQ_TX_PAR: begin
                    if (half_tick_i) begin
                        half_reg <= half_reg + 3'h1;
                        if (half_reg + 3'h1 == `UIRQ_HALF_BIT) begin
                            half_reg  <= 3'h0;
                            txd_o     <= 1'b1;
                            state_reg <= uirq_pkg::UIRQ_TX_STOP;
                        end
                    end
                end
                uirq_pkg::UIRQ_TX_STOP: begin
                    if (half_tick_i) begin
                        half_reg <= half_reg + 3'h1;
                        if (half_reg + 3'h1 == stop_h) begin
                            half_reg  <= 3'h0;
                            state_reg <= uirq_pkg::UIRQ_TX_IDLE;
                        end
                    end
                end
                default: state_reg <= uirq_pkg::UIRQ_TX_IDLE;
            endcase
        end
    end

    assign idle_o = (state_reg == uirq_pkg::UIRQ_TX_IDLE) && hold_empty_o;
endmodule

// File: uirq_checker_assertions.sv
`timescale 1ns/10ps
`include "uirq_regs.svh"
// Bus answer timing and ident/format relations seen at the top ports
module uirq_checker #(
    parameter int ADDR_W = 5
) (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [ADDR_W-1:0]   wb_adr_i,
    input  wire logic [31:0]         wb_dat_o,
    input  wire logic                wb_ack_o,
    input  wire logic                serial_out_pin_o,
    input  wire logic                line_state_rd_o,
    input  wire uirq_pkg::uirq_lcr_t line_format_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic take;
    logic rd_id;
    // Taking edge of a request, and reads of the ident place
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rd_id = take && !wb_we_i && wb_adr_i[4:0] == `UIRQ_OFF_IIR;
    a_ack_next: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a one-cycle answer");
    a_ident_idle: assert property (rd_id |=> !wb_dat_o[0] || wb_dat_o[3:1] == 3'h0)
        else $error("idle ident with code bits");
    a_ident_unused: assert property (rd_id |=> wb_dat_o[5:4] == 2'h0)
        else $error("ident bits 5:4 set");
    a_ident_code: assert property (rd_id |=> wb_dat_o[3:0] inside {4'h1, 4'h6, 4'h4, 4'hc, 4'h2, 4'h0})
        else $error("ident code illegal");
    a_ident_fifo: assert property (rd_id |=> wb_dat_o[7] == wb_dat_o[6] && (!wb_dat_o[3] || wb_dat_o[7]))
        else $error("ident mode bits wrong");
    a_format_read: assert property (take && !wb_we_i && wb_adr_i[4:0] == `UIRQ_OFF_LCR
        |=> wb_dat_o[7:0] == line_format_o)
        else $error("format read differs");
    a_break_low: assert property (line_format_o.brk && $past(line_format_o.brk) |-> !serial_out_pin_o)
        else $error("break not on pin");
    a_line_clear: assert property (take && !wb_we_i && wb_adr_i[4:0] == `UIRQ_OFF_LSR |=> line_state_rd_o)
        else $error("line state read not signalled");
endmodule
bind uirq_top uirq_checker #(.ADDR_W(ADDR_W)) chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serial_out_pin_o(serial_out_pin_o),
    .line_state_rd_o(line_state_rd_o), .line_format_o(line_format_o));

// File: uirq_host.sv
`timescale 1ns/10ps
// Host model: one classic bus cycle at a time
module uirq_host (
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    output logic             cyc_o,
    output logic             we_o,
    output logic [4:0]       adr_o,
    output logic [31:0]      dat_o
);
    initial {cyc_o, we_o, adr_o, dat_o} = '0;
    // Holds the request until ack is sampled; released lines show junk, not old values
    task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        @(posedge clk_i);
        {cyc_o, we_o, adr_o, dat_o} <= {1'b1, w, a, 24'h000000, d};
        do begin
            @(posedge clk_i);
        end while (ack_i !== 1'b1);
        q = dat_i[7:0];
        {cyc_o, we_o, adr_o, dat_o} <= {1'b0, ~w, ~a, ~dat_o};
    endtask
endmodule

// File: test_uart_irq_ident_line_format.sv
`timescale 1ns/10ps
`include "uirq_regs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("BAD %0t got %h want %h", $time, g, e); end end
module test_uart_irq_ident_line_format;
    logic        clk_i = 1'b0, rst_i = 1'b1, half_tick = 1'b0, trig = 1'b0, tmo = 1'b0;
    logic        cyc, we, ack, pin;
    logic [2:0]  ev = 3'h0;
    logic [4:0]  adr;
    logic [31:0] wdat, rdat;
    logic [7:0]  q;
    logic [15:0] div;
    int          failures = 0, comparisons = 0;
    uirq_pkg::uirq_lcr_t fmt;
    uirq_host host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .we_o(we),
        .adr_o(adr), .dat_o(wdat));
    uirq_top #(.ADDR_W(5)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .rx_valid_i(ev[2]), .rx_char_i({8'hc3, 2'h1}),
        .rx_break_i(ev[1]), .rx_overrun_i(1'b0), .rx_trig_i(trig), .rx_timeout_i(tmo),
        .rx_fifo_data_i(8'h3c), .modem_change_i(ev[0]), .modem_state_i(8'ha5),
        .half_tick_i(half_tick), .serial_out_pin_o(pin), .rx_buffer_rd_o(),
        .line_state_rd_o(), .modem_state_rd_o(), .rx_fifo_clr_o(), .tx_fifo_clr_o(),
        .rx_trig_level_o(), .dma_mode_o(), .divisor_o(div), .line_format_o(fmt));
    // Half-bit tick every other cycle, so one serial bit spans four cycles
    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) half_tick <= ~half_tick;
    task automatic wrap_up();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic rdc(input logic [4:0] a, input logic [7:0] e);
        host.xfer(1'b0, a, 8'h00, q);
        `CHK(q, e)
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, d, q);
    endtask
    // Events {rx char, break, modem change} for one cycle
    task automatic pulse(input logic [2:0] v);
        @(posedge clk_i);
        ev <= v;
        @(posedge clk_i);
        ev <= 3'h0;
    endtask
    // Samples n bits near mid-bit from the start edge; bit 0 of e is the start bit
    task automatic frame(input int n, input logic [11:0] e);
        logic [11:0] got;
        int k;
        got = '0;
        k = 0;
        while (pin !== 1'b0 && k < 200) begin
            @(posedge clk_i);
            k++;
        end
        @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            got[i] = pin;
            repeat (4) @(posedge clk_i);
        end
        `CHK(got, e)
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(`UIRQ_OFF_IIR, 8'h01);
        rdc(`UIRQ_OFF_LCR, 8'h00);
        `CHK(div, `UIRQ_DIV_RST)
        for (int i = 0; i < 4; i++) begin
            wr(`UIRQ_OFF_LCR, {6'h0e, i[1:0]});
            rdc(`UIRQ_OFF_LCR, {6'h0e, i[1:0]});
        end
        wr(`UIRQ_OFF_LCR, 8'h83);
        wr(`UIRQ_OFF_DATA, 8'h34);
        wr(`UIRQ_OFF_IER, 8'h12);
        @(posedge clk_i);
        `CHK(div, 16'h1234)
        wr(`UIRQ_OFF_LCR, 8'h03);
        pulse(3'h1);
        rdc(`UIRQ_OFF_IIR, 8'h01);
        rdc(`UIRQ_OFF_MSR, 8'ha5);
        wr(`UIRQ_OFF_IER, 8'h0f);
        rdc(`UIRQ_OFF_IIR, 8'h02);
        rdc(`UIRQ_OFF_IIR, 8'h01);
        pulse(3'h3);
        rdc(`UIRQ_OFF_IIR, 8'h06);
        rdc(`UIRQ_OFF_LSR, 8'h70);
        rdc(`UIRQ_OFF_IIR, 8'h00);
        rdc(`UIRQ_OFF_MSR, 8'ha5);
        rdc(`UIRQ_OFF_IIR, 8'h01);
        pulse(3'h4);
        rdc(`UIRQ_OFF_IIR, 8'h04);
        rdc(`UIRQ_OFF_DATA, 8'hc3);
        rdc(`UIRQ_OFF_IIR, 8'h01);
        wr(`UIRQ_OFF_IIR, 8'h01);
        rdc(`UIRQ_OFF_IIR, 8'hc1);
        tmo <= 1'b1;
        rdc(`UIRQ_OFF_IIR, 8'hcc);
        trig <= 1'b1;
        rdc(`UIRQ_OFF_IIR, 8'hc4);
        trig <= 1'b0;
        tmo <= 1'b0;
        wr(`UIRQ_OFF_IIR, 8'h00);
        rdc(`UIRQ_OFF_IIR, 8'h01);
        wr(`UIRQ_OFF_LCR, 8'h0b);
        wr(`UIRQ_OFF_DATA, 8'h55);
        frame(11, 12'h6aa);
        wr(`UIRQ_OFF_LCR, 8'h3b);
        wr(`UIRQ_OFF_DATA, 8'h54);
        frame(11, 12'h4a8);
        wr(`UIRQ_OFF_LCR, 8'h00);
        wr(`UIRQ_OFF_DATA, 8'hff);
        frame(7, 12'h07e);
        wr(`UIRQ_OFF_DATA, 8'h0f);
        wr(`UIRQ_OFF_LCR, 8'h43);
        @(posedge clk_i);
        `CHK(pin, 1'b0)
        repeat (60) @(posedge clk_i);
        rdc(`UIRQ_OFF_LSR, 8'h60);
        wr(`UIRQ_OFF_LCR, 8'h03);
        @(posedge clk_i);
        `CHK(pin, 1'b1)
        wrap_up();
    end
    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        wrap_up();
    end
endmodule
